// ===== verilog/cpo_pkg.sv
// Shared constants and types of the configuration memory output control.
package cpo_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_TIME_NS = 1000000;
   // A least time, so the cycle count rounds up.
   localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;

   // ==========================================================
   // Array geometry
   // ==========================================================
   localparam int DEF_DEPTH = 1024;
   localparam int DEF_WORD_W = 8;

   // ==========================================================
   // Synchronised pin vector layout and reset levels
   // ==========================================================
   localparam int PIN_COUNT = 4;
   localparam int PIN_CONFIG_CLOCK = 0;
   localparam int PIN_CHIP_EN_N = 1;
   localparam int PIN_OE_RESET_N = 2;
   localparam int PIN_VCC_LOW = 3;
   // Chip enable idles high (standby), everything else low.
   localparam logic [PIN_COUNT-1:0] PIN_RST = 4'h2;

   // ==========================================================
   // Reset values of control outputs
   // ==========================================================
   localparam logic RST_CHAIN_N = 1'b1;
   localparam logic RST_STANDBY = 1'b1;

   typedef enum logic [0:0] {CPO_ST_POR, CPO_ST_RUN} cpo_state_t;

endpackage

// ===== verilog/cpo_sync.sv
// Two flip-flop synchroniser for the asynchronous control pins.
`timescale 1ns/10ps
module cpo_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Pins in and synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } cpo_sync_state_t;

   cpo_sync_state_t q;
   cpo_sync_state_t d;

   // ==========================================================
   // Stages
   // ==========================================================
   // The first stage feeds only the second, so metastability never spreads.
   always_comb begin
      d = q;
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   // Reset loads the idle levels of the pins.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q <= {RESET_VAL, RESET_VAL};
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;

endmodule

// ===== verilog/cpo_ctrl.sv
// Output control of a serial configuration memory: address, data, chain.
`timescale 1ns/10ps
// Functional notes
// - After power-up the block pulls output-enable/reset low until its 1 ms initialisation ends.
// - A supply dip below 2.0 V resets the block's internal state.
// - The reset sense of output-enable/reset is fixed active low and cannot be inverted.
// - With chip enable high the block is in standby with its address held at zero.
// - With chip enable high the data output floats whatever output-enable/reset does.
// - Enabled and not past the last address, each clock advances the bit (the address once per word), drives data and holds chain enable high.
// - Enabled and past the last address, the address freezes, data floats, chain enable goes low and current drops.
// - The last address is the top of the array and the counter has one extra overflow state beyond it.
// - The clock after the last data bit drives chain enable low and floats data so the next device takes over.
// - The master supplies the configuration clock and each valid rising edge advances the bit counter, and the address counter once per word.
module cpo_ctrl #(
   parameter int DEPTH = cpo_pkg::DEF_DEPTH,
   parameter int WORD_W = cpo_pkg::DEF_WORD_W,
   parameter int POR_CYCLES = cpo_pkg::POR_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Configuration pins from the master
   input wire logic config_clock,
   input wire logic chip_enable_n,
   // Open-drain output-enable/reset pin
   input wire logic oe_reset_n_in,
   output logic oe_reset_n_out,
   output logic oe_reset_n_oe,
   // Data and cascade outputs
   output logic data_out,
   output logic data_oe,
   output logic chain_enable_out_n,
   // Supply monitor, high while the supply is below 2.0 V
   input wire logic vcc_low,
   // Array read port, combinational read
   output logic [$clog2(DEPTH)-1:0] mem_addr,
   input wire logic [WORD_W-1:0] mem_rdata,
   // Status
   output logic standby,
   output logic reduced_current,
   output logic init_done
);

   localparam int MEM_W = $clog2(DEPTH);
   // One bit more than the array needs, for the overflow state.
   localparam int ADDR_W = MEM_W + 1;
   localparam int BIT_W = $clog2(WORD_W);
   localparam int POR_W = $clog2(POR_CYCLES + 1);
   localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
   localparam logic [ADDR_W-1:0] ADDR_OVF = ADDR_W'(DEPTH);
   localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WORD_W - 1);
   localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

   typedef struct packed {
      cpo_pkg::cpo_state_t st;
      logic [POR_W-1:0] por_cnt;
      logic [ADDR_W-1:0] addr;
      logic [BIT_W-1:0] bitn;
      logic clk_prev;
      logic data;
      logic data_en;
      logic chain_n;
      logic stby;
      logic reduced;
   } cpo_ctrl_state_t;

   localparam cpo_ctrl_state_t Q_RST = '{
      st: cpo_pkg::CPO_ST_POR,
      por_cnt: '0,
      addr: '0,
      bitn: '0,
      clk_prev: 1'b0,
      data: 1'b0,
      data_en: 1'b0,
      chain_n: cpo_pkg::RST_CHAIN_N,
      stby: cpo_pkg::RST_STANDBY,
      reduced: 1'b0
   };

   cpo_ctrl_state_t q;
   cpo_ctrl_state_t d;
   logic [cpo_pkg::PIN_COUNT-1:0] pins_raw;
   logic [cpo_pkg::PIN_COUNT-1:0] pins_s;
   logic config_clock_s;
   logic ce_n_s;
   logic oe_s;
   logic vlow_s;
   logic clk_rise;
   logic live;

   // True once the address has run beyond the top of the array.
   function automatic logic past_last(input logic [ADDR_W-1:0] a);
      past_last = (a > LAST_ADDR);
   endfunction

   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   // All control pins, the supply monitor included, are asynchronous to the core clock.
   always_comb begin
      pins_raw = '0;
      pins_raw[cpo_pkg::PIN_CONFIG_CLOCK] = config_clock;
      pins_raw[cpo_pkg::PIN_CHIP_EN_N] = chip_enable_n;
      pins_raw[cpo_pkg::PIN_OE_RESET_N] = oe_reset_n_in;
      pins_raw[cpo_pkg::PIN_VCC_LOW] = vcc_low;
   end

   cpo_sync #(
      .WIDTH(cpo_pkg::PIN_COUNT),
      .RESET_VAL(cpo_pkg::PIN_RST)
   ) u_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   assign config_clock_s = pins_s[cpo_pkg::PIN_CONFIG_CLOCK];
   assign ce_n_s = pins_s[cpo_pkg::PIN_CHIP_EN_N];
   assign oe_s = pins_s[cpo_pkg::PIN_OE_RESET_N];
   assign vlow_s = pins_s[cpo_pkg::PIN_VCC_LOW];
   // Rising edge of the master clock, seen after synchronisation.
   assign clk_rise = config_clock_s && !q.clk_prev;

   // ==========================================================
   // Next state
   // ==========================================================
   // The reset sense of the pin is hard wired; no setting reaches it.
   always_comb begin
      d = q;
      d.clk_prev = config_clock_s;
      // Initialisation wait, restarted by any supply dip.
      if (vlow_s) begin
         d.st = cpo_pkg::CPO_ST_POR;
         d.por_cnt = '0;
      end else if (q.st == cpo_pkg::CPO_ST_POR) begin
         if (q.por_cnt == POR_LAST) begin
            d.st = cpo_pkg::CPO_ST_RUN;
         end else begin
            d.por_cnt = q.por_cnt + 1'b1;
         end
      end
      live = (q.st == cpo_pkg::CPO_ST_RUN) && !vlow_s && oe_s && !ce_n_s;
      // Counters: held at zero unless enabled, frozen once past the top.
      if (!live) begin
         d.addr = '0;
         d.bitn = '0;
      end else if (clk_rise && !past_last(q.addr)) begin
         if (q.bitn == BIT_LAST) begin
            d.bitn = '0;
            d.addr = q.addr + 1'b1;
         end else begin
            d.bitn = q.bitn + 1'b1;
         end
      end
      // Outputs follow the new counter values so they stay aligned.
      d.stby = ce_n_s;
      d.data_en = live && !past_last(d.addr);
      d.chain_n = !(live && past_last(d.addr));
      d.reduced = live && past_last(d.addr);
      d.data = d.data_en ? mem_rdata[d.bitn] : 1'b0;
   end

   // State register.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q <= Q_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // The pin is only ever pulled low; the external pull-up lifts it.
   assign oe_reset_n_out = 1'b0;
   assign oe_reset_n_oe = (q.st == cpo_pkg::CPO_ST_POR);
   // The array index drops the overflow bit, so top plus one wraps to 0.
   assign mem_addr = d.addr[MEM_W-1:0];
   assign data_out = q.data;
   assign data_oe = q.data_en;
   assign chain_enable_out_n = q.chain_n;
   assign standby = q.stby;
   assign reduced_current = q.reduced;
   assign init_done = (q.st == cpo_pkg::CPO_ST_RUN);

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   property p_por_hold;
      $rose(init_done) |-> $past(q.por_cnt) == POR_LAST &&
         $past(oe_reset_n_oe) && !oe_reset_n_oe;
   endproperty
   a_por_hold: assert property (p_por_hold)
      else $error("Initialisation ended at the wrong count.");

   property p_brownout;
      vlow_s |=> !init_done && q.por_cnt == '0 && oe_reset_n_oe;
   endproperty
   a_brownout: assert property (p_brownout)
      else $error("Supply dip did not reset the block.");

   property p_fixed_sense;
      (init_done && !oe_s) |=> q.addr == '0 && !data_oe;
   endproperty
   a_fixed_sense: assert property (p_fixed_sense)
      else $error("Low output-enable did not reset the address.");

   property p_standby;
      ce_n_s |=> standby && q.addr == '0 && q.bitn == '0;
   endproperty
   a_standby: assert property (p_standby)
      else $error("Chip enable high did not give standby.");

   property p_float_ce;
      (ce_n_s && oe_s) |=> !data_oe && chain_enable_out_n;
   endproperty
   a_float_ce: assert property (p_float_ce)
      else $error("Data driven while chip enable high.");

   property p_advance;
      (init_done && !vlow_s && oe_s && !ce_n_s && clk_rise &&
       q.addr < LAST_ADDR)
      |=> (q.bitn == $past(q.bitn) + 1'b1 ||
           q.addr == $past(q.addr) + 1'b1) &&
          data_oe && chain_enable_out_n;
   endproperty
   a_advance: assert property (p_advance)
      else $error("Enabled clock edge did not advance the read.");

   property p_freeze;
      (init_done && !vlow_s && oe_s && !ce_n_s && past_last(q.addr))
      |=> $stable(q.addr) && !data_oe && !chain_enable_out_n &&
          reduced_current;
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("Past the top the outputs did not freeze.");

   property p_terminal;
      (init_done && !vlow_s && oe_s && !ce_n_s && clk_rise &&
       q.addr == LAST_ADDR && q.bitn == BIT_LAST)
      |=> q.addr == ADDR_OVF && mem_addr == '0;
   endproperty
   a_terminal: assert property (p_terminal)
      else $error("Top address did not step to the overflow state.");

   property p_oe_low;
      (init_done && !vlow_s && !oe_s && !ce_n_s)
      |=> chain_enable_out_n && !standby && !reduced_current;
   endproperty
   a_oe_low: assert property (p_oe_low)
      else $error("Output-enable low gave wrong outputs.");

   property p_handover;
      (init_done && !vlow_s && oe_s && !ce_n_s && clk_rise &&
       q.addr == LAST_ADDR && q.bitn == BIT_LAST)
      ##1 (oe_s && !ce_n_s && !vlow_s)
      |=> !chain_enable_out_n && !data_oe;
   endproperty
   a_handover: assert property (p_handover)
      else $error("Last bit did not hand over to the next device.");

   property p_no_edge;
      (init_done && !vlow_s && oe_s && !ce_n_s && !clk_rise)
      |=> $stable(q.addr) && $stable(q.bitn);
   endproperty
   a_no_edge: assert property (p_no_edge)
      else $error("Counters moved without a clock edge.");

   c_full_read: cover property ($rose(reduced_current));
   c_handover: cover property ($fell(chain_enable_out_n));
   c_standby: cover property (init_done && $rose(standby));
   c_brownout: cover property (init_done ##1 vlow_s);

endmodule

// ===== test/cpo_master_model.sv
// Behavioural configuration master: clock, chip enable and reset pull.
`timescale 1ns/10ps
module cpo_master_model (
   // Clock
   input wire logic core_clk,
   // Pins toward the memory
   output logic config_clock,
   output logic chip_enable_n,
   output logic init_pull
);
   // ==========================================================
   // Pin drivers
   // ==========================================================
   // Idle levels: clock still, memory deselected, wire released.
   initial begin
      config_clock = 1'b0;
      chip_enable_n = 1'b1;
      init_pull = 1'b0;
   end

   // Three cycles high and low, so the two-flop sampler sees each phase.
   task automatic pulses(input int n);
      repeat (n) begin
         @(negedge core_clk);
         config_clock = 1'b1;
         repeat (3) @(negedge core_clk);
         config_clock = 1'b0;
         repeat (3) @(negedge core_clk);
      end
   endtask

   // Control levels change together, then settle past the sampler delay.
   task automatic set_pins(input logic ce_n, input logic pull);
      @(negedge core_clk);
      chip_enable_n = ce_n;
      init_pull = pull;
      repeat (6) @(negedge core_clk);
   endtask
endmodule

// ===== test/config_prom_output_control_tb_top.sv
// Self-checking bench of the configuration memory output control.
`timescale 1ns/10ps
module config_prom_output_control_tb_top;
   localparam int POR = 20;
   logic core_clk;
   logic rstn;
   logic vcc_low;
   logic config_clock, chip_enable_n, init_pull, oe_wire;
   logic oe_out, oe_oe, data_out, data_oe, chain_n;
   logic standby, reduced_current, init_done;
   logic [1:0] mem_addr;
   logic [7:0] mem_rdata;
   logic [7:0] words [4];
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;

   // ==========================================================
   // Clock, wire and array
   // ==========================================================
   always #5 core_clk = ~core_clk;
   // Open-drain wire with a pull-up: low while either party pulls.
   assign oe_wire = ~((oe_oe & ~oe_out) | init_pull);
   // Combinational array read with no wait states.
   assign mem_rdata = words[mem_addr];

   cpo_master_model master_u (
      .core_clk(core_clk),
      .config_clock(config_clock),
      .chip_enable_n(chip_enable_n),
      .init_pull(init_pull)
   );

   cpo_ctrl #(.DEPTH(4), .WORD_W(8), .POR_CYCLES(POR)) dut_u (
      .core_clk(core_clk),
      .rstn(rstn),
      .config_clock(config_clock),
      .chip_enable_n(chip_enable_n),
      .oe_reset_n_in(oe_wire),
      .oe_reset_n_out(oe_out),
      .oe_reset_n_oe(oe_oe),
      .data_out(data_out),
      .data_oe(data_oe),
      .chain_enable_out_n(chain_n),
      .vcc_low(vcc_low),
      .mem_addr(mem_addr),
      .mem_rdata(mem_rdata),
      .standby(standby),
      .reduced_current(reduced_current),
      .init_done(init_done)
   );

   // ==========================================================
   // Checking and closing
   // ==========================================================
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A hang shows as a cycle count far beyond the whole sequence.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end

   // Waits a bounded time for the initialisation wait to end.
   task automatic wait_init();
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < POR + 10) begin
         @(negedge core_clk);
         n++;
      end
      check(8'(init_done), 8'h01);
      check(8'(oe_oe), 8'h00);
      repeat (4) @(negedge core_clk);
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_init();
      check(8'(oe_oe), 8'h01);
      check(8'(oe_out), 8'h00);
      check(8'(oe_wire), 8'h00);
      repeat (POR - 5) @(negedge core_clk);
      check(8'(init_done), 8'h00);
      wait_init();
      check(8'(standby), 8'h01);
      check(8'(data_oe), 8'h00);
   endtask

   // Deselected with the wire high: clocks must not count.
   task automatic t_standby();
      master_u.pulses(2);
      check(8'(data_oe), 8'h00);
      check(8'(standby), 8'h01);
      check(8'(chain_n), 8'h01);
      check(8'(mem_addr), 8'h00);
   endtask

   // Whole array LSB first, then past the top and frozen.
   task automatic t_stream();
      master_u.set_pins(1'b0, 1'b0);
      check(8'(standby), 8'h00);
      check(8'(data_oe), 8'h01);
      for (int a = 0; a < 4; a++) begin
         for (int b = 0; b < 8; b++) begin
            check(8'(data_out), 8'(words[a][b]));
            check(8'(chain_n), 8'h01);
            master_u.pulses(1);
         end
      end
      for (int k = 0; k < 2; k++) begin
         check(8'(data_oe), 8'h00);
         check(8'(chain_n), 8'h00);
         check(8'(reduced_current), 8'h01);
         check(8'(mem_addr), 8'h00);
         master_u.pulses(2);
      end
   endtask

   // Wire pulled low while selected, then standby mid-word.
   task automatic t_reset_pin();
      master_u.set_pins(1'b0, 1'b1);
      master_u.pulses(2);
      check(8'(data_oe), 8'h00);
      check(8'(chain_n), 8'h01);
      check(8'(reduced_current), 8'h00);
      check(8'(standby), 8'h00);
      check(8'(mem_addr), 8'h00);
      master_u.set_pins(1'b0, 1'b0);
      check(8'(data_out), 8'(words[0][0]));
      master_u.pulses(3);
      check(8'(data_out), 8'(words[0][3]));
      master_u.set_pins(1'b1, 1'b0);
      check(8'(data_oe), 8'h00);
      check(8'(standby), 8'h01);
      master_u.set_pins(1'b0, 1'b0);
      check(8'(data_out), 8'(words[0][0]));
   endtask

   // Supply dip mid-read restarts the initialisation wait.
   task automatic t_brownout();
      master_u.pulses(5);
      @(negedge core_clk);
      vcc_low = 1'b1;
      repeat (4) @(negedge core_clk);
      vcc_low = 1'b0;
      repeat (2) @(negedge core_clk);
      check(8'(init_done), 8'h00);
      check(8'(oe_wire), 8'h00);
      check(8'(data_oe), 8'h00);
      wait_init();
      check(8'(data_out), 8'(words[0][0]));
   endtask

   initial begin
      // Start levels: reset held, supply good, array contents known.
      core_clk = 1'b0;
      rstn = 1'b0;
      vcc_low = 1'b0;
      // Bit 0 of the first word is set, so a restart is told apart from
      // a data line that simply sits low.
      words = '{8'hA5, 8'hC3, 8'h81, 8'h7E};
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      t_init();
      t_standby();
      t_stream();
      t_reset_pin();
      t_brownout();
      complete_run();
   end
endmodule
